// ### verilog/rsr_pkg.sv
// Shared constants and types for the record, statistic and result register slice.
package rsr_pkg;

    // Register byte addresses; each register is two bytes, low byte at the even address.
    localparam logic [6:0] ADDR_REC_INFO_B = 7'h68;
    localparam logic [6:0] ADDR_RECORD_COUNT = 7'h6A;
    localparam logic [6:0] ADDR_PEAK_ALARM_BIN = 7'h70;
    localparam logic [6:0] ADDR_STAT_SELECT = 7'h72;
    localparam logic [6:0] ADDR_STAT_RESULT = 7'h78;
    localparam logic [6:0] ADDR_FUNDAMENTAL_FREQ = 7'h7A;

    // Reset values.
    localparam logic [15:0] RESET_STAT_SELECT = 16'h0000;
    localparam logic [15:0] RESET_FUNDAMENTAL_FREQ = 16'h0000;
    localparam logic [15:0] RESET_STAT_RESULT = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED = 16'h0000;

    // Field positions and limits.
    localparam int AVG_COUNT_MSB = 3;
    localparam int RECORD_COUNT_MSB = 3;
    localparam logic [3:0] RECORD_COUNT_MAX = 4'h9;
    localparam int ALARM_BIN_MSB = 11;
    localparam int STAT_SEL_MSB = 2;
    localparam int FRAC_INT_MSB = 15;

    // Statistic selector codes.
    localparam logic [2:0] STAT_MEAN = 3'h0;
    localparam logic [2:0] STAT_STD_DEV = 3'h1;
    localparam logic [2:0] STAT_PEAK = 3'h2;
    localparam logic [2:0] STAT_PEAK_TO_PEAK = 3'h3;
    localparam logic [2:0] STAT_CREST = 3'h4;
    localparam logic [2:0] STAT_KURTOSIS = 3'h5;
    localparam logic [2:0] STAT_SKEWNESS = 3'h6;
    localparam int NUM_STATS = 7;

    // Serial frame layout: 16 bits, MSB first, write flag, address, data byte.
    localparam int FRAME_BITS = 16;

    // Alarm band limits as tenths of the fundamental; the last stop is the maximum frequency.
    localparam int NUM_BANDS = 6;
    localparam int BAND_WIDTH = 20;
    localparam int TENTHS_DIV = 10;
    localparam int BAND_START_TENTHS [NUM_BANDS] = '{2, 8, 18, 28, 38, 102};
    localparam int BAND_STOP_TENTHS [NUM_BANDS] = '{8, 18, 28, 38, 102, 0};

    // One received host frame.
    typedef struct packed {
        logic write;
        logic [6:0] addr;
        logic [7:0] data;
    } rsr_frame_t;

    // Band limits, one pair per alarm band.
    typedef struct packed {
        logic [BAND_WIDTH-1:0] start_hz;
        logic [BAND_WIDTH-1:0] stop_hz;
    } rsr_band_t;

    // Serial slave states, one-hot.
    typedef enum logic [1:0] {
        RSR_SPI_IDLE = 2'b01,
        RSR_SPI_SHIFT = 2'b10
    } rsr_spi_state_t;

endpackage : rsr_pkg

// ### verilog/rsr_spi_slave.sv
// Serial host port slave: synchronises the pins, shifts 16-bit frames in and out.
`timescale 1ns/1ps
module rsr_spi_slave (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic sclk_pin,
    input wire logic cs_pin_n,
    input wire logic din_pin,
    input wire logic [15:0] tx_word,
    output logic dout,
    output logic frame_valid,
    output rsr_pkg::rsr_frame_t frame
);
    import rsr_pkg::*;

    logic [2:0] sclk_sync;
    logic [1:0] cs_sync_n;
    logic [1:0] din_sync;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [4:0] bit_count;
    rsr_spi_state_t state;
    wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    wire sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    wire frame_done = (bit_count == 5'(FRAME_BITS));

    // Two flip-flops per pin; the third sclk stage only feeds the edge detector.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync <= 3'h7;
            cs_sync_n <= 2'h3;
            din_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk_pin};
            cs_sync_n <= {cs_sync_n[0], cs_pin_n};
            din_sync <= {din_sync[0], din_pin};
        end
    end

    // Clock idles high: data is taken on rising edges and changed on falling ones.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= RSR_SPI_IDLE;
            shift_in <= 16'h0000;
            shift_out <= 16'h0000;
            bit_count <= 5'h00;
            dout <= 1'b0;
            frame_valid <= 1'b0;
            frame <= '0;
        end else begin
            frame_valid <= 1'b0;
            case (state)
                RSR_SPI_IDLE: begin
                    if (!cs_sync_n[1]) begin
                        shift_out <= tx_word;
                        dout <= tx_word[15];
                        bit_count <= 5'h00;
                        state <= RSR_SPI_SHIFT;
                    end
                end
                RSR_SPI_SHIFT: begin
                    if (cs_sync_n[1]) begin
                        // A short or long frame is dropped whole rather than half applied.
                        frame_valid <= frame_done;
                        frame <= shift_in;
                        state <= RSR_SPI_IDLE;
                    end else if (sclk_rise) begin
                        shift_in <= {shift_in[14:0], din_sync[1]};
                        bit_count <= bit_count + 5'h01;
                    end else if (sclk_fall && bit_count != 5'h00) begin
                        shift_out <= {shift_out[14:0], 1'b0};
                        dout <= shift_out[14];
                    end
                end
                default: state <= RSR_SPI_IDLE;
            endcase
        end
    end

endmodule : rsr_spi_slave

// ### verilog/rsr_band_loader.sv
// Derives the start frequency of every spectral alarm band, and every stop but the last, from the fundamental.
`timescale 1ns/1ps
module rsr_band_loader #(
    parameter logic [rsr_pkg::BAND_WIDTH-1:0] MAX_FREQ_HZ = 20'h02710
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [15:0] fund_hz,
    output rsr_pkg::rsr_band_t bands [rsr_pkg::NUM_BANDS],
    output logic bands_loaded
);
    import rsr_pkg::*;

    // Exact tenths scaling; the divide by a constant folds into plain logic.
    for (genvar b = 0; b < NUM_BANDS; b++) begin : g_band
        wire [23:0] start_prod = 24'(fund_hz) * 24'(BAND_START_TENTHS[b]);
        wire [23:0] stop_prod = 24'(fund_hz) * 24'(BAND_STOP_TENTHS[b]);
        wire [23:0] start_q = start_prod / 24'(TENTHS_DIV);
        wire [23:0] stop_q = stop_prod / 24'(TENTHS_DIV);
        wire [BAND_WIDTH-1:0] stop_hz = (b == NUM_BANDS - 1) ? MAX_FREQ_HZ :
                                        stop_q[BAND_WIDTH-1:0];

        // Limits only move on a load, so the alarm logic sees a stable set otherwise.
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                bands[b] <= '0;
            end else if (load) begin
                bands[b].start_hz <= start_q[BAND_WIDTH-1:0];
                bands[b].stop_hz <= stop_hz;
            end
        end
    end

    // One-cycle notice that a new set of limits stands.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bands_loaded <= 1'b0;
        end else begin
            bands_loaded <= load;
        end
    end

endmodule : rsr_band_loader

// ### verilog/rsr_record_stats_regs.sv
// Register slice for record count, alarm bin, statistic selection and the fundamental frequency.
`timescale 1ns/1ps
module rsr_record_stats_regs #(
    parameter logic [rsr_pkg::BAND_WIDTH-1:0] MAX_FREQ_HZ = 20'h02710
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    // Serial host port pins.
    input wire logic sclk_pin,
    input wire logic cs_pin_n,
    input wire logic din_pin,
    output logic dout,
    // State from the record, alarm and statistic engines on this clock.
    input wire logic [15:0] averaging_count,
    input wire logic [3:0] record_count_in,
    input wire logic [11:0] peak_alarm_bin_in,
    input wire logic [rsr_pkg::NUM_STATS-1:0][15:0] stat_values,
    // Settings and derived limits for the alarm engine.
    output logic [15:0] statistic_select,
    output logic [15:0] fundamental_freq,
    output rsr_pkg::rsr_band_t bands [rsr_pkg::NUM_BANDS],
    output logic bands_loaded
);
    import rsr_pkg::*;

    // Host view: one 16-bit word per even byte
    // address, its upper byte at the odd one.
    // Record info and the record counter come first.
    // The alarm bin and the selector follow.
    // The result and the fundamental close the slice.
    // Only the selector and the fundamental hold
    // host data; the other words mirror engines.
    // Words outside the slice read as zero, so a
    // host can probe addresses without side effects.

    // Frame from the serial slave and the word it sends in the next frame.
    rsr_frame_t frame;
    logic frame_valid;
    logic [15:0] tx_word;

    // Captured read-only views and the result register.
    logic [15:0] record_count;
    logic [15:0] peak_alarm_bin;
    logic [15:0] spectral_record_info_b;
    logic [15:0] statistic_result;
    logic band_load;

    // The serial slave owns the pins, their synchronisers and the output bit.
    // Each pin passes two flip-flops before any
    // logic reads it, as the host clock is foreign.
    // A frame is handed over only when select rises
    // after exactly sixteen serial clocks, so a cut
    // frame changes nothing; an aborted transfer
    // never leaves a half-written fundamental.
    // The price is latency: a write acts a few
    // clocks after select rises, never while the
    // frame is still open.
    rsr_spi_slave u_spi (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .sclk_pin(sclk_pin),
        .cs_pin_n(cs_pin_n),
        .din_pin(din_pin),
        .tx_word(tx_word),
        .dout(dout),
        .frame_valid(frame_valid),
        .frame(frame)
    );

    // Address decode: both bytes of a register share the word, the odd one is the upper byte.
    // The low address bit only steers byte writes;
    // reads always return the whole word.
    // The hit wires depend only on the stored
    // frame, which is reloaded each time a frame
    // closes, at the same edge that raises the strobe.
    wire [6:0] word_addr = {frame.addr[6:1], 1'b0};
    wire upper_byte = frame.addr[0];
    wire host_write = frame_valid & frame.write;
    wire host_read = frame_valid & ~frame.write;
    wire hit_info_b = (word_addr == ADDR_REC_INFO_B);
    wire hit_record_count = (word_addr == ADDR_RECORD_COUNT);
    wire hit_alarm_bin = (word_addr == ADDR_PEAK_ALARM_BIN);
    wire hit_select = (word_addr == ADDR_STAT_SELECT);
    wire hit_result = (word_addr == ADDR_STAT_RESULT);
    wire hit_fund = (word_addr == ADDR_FUNDAMENTAL_FREQ);

    // Only the two read-write registers take writes; the others have no write path.
    // A write to a read-only word, or to a word
    // outside the slice, forms no enable, so
    // nothing stored can move.
    // Reads never disturb stored data either;
    // they only load the answer word.
    wire write_select = host_write & hit_select;
    wire write_fund = host_write & hit_fund;
    wire write_fund_upper = write_fund & upper_byte;

    // Selector byte update; the untouched byte keeps its value.
    // Bits above the metric code are stored as
    // written, so flags parked there by software
    // read back unchanged.
    wire [15:0] next_statistic_select = upper_byte ?
        {frame.data, statistic_select[7:0]} :
        {statistic_select[15:8], frame.data};

    // Fundamental byte update, assembled the same way.
    // Bytes land one frame at a time. The limits
    // use whatever low byte stands when the upper
    // byte arrives, so a host that changes both
    // bytes should write the low byte first. The
    // other order still loads, but from a value
    // that mixes old and new bytes.
    wire [15:0] next_fundamental_freq = upper_byte ?
        {frame.data, fundamental_freq[7:0]} :
        {fundamental_freq[15:8], frame.data};

    // Band limits follow an upper-byte write, but a zero value must not disturb them.
    // Zero means the function is off, so the host
    // may clear the register without losing limits
    // that were loaded earlier.
    // The test looks at the assembled value, so a
    // zero upper byte over a nonzero low byte loads.
    // A low-byte write never loads, even when it
    // makes the value nonzero.
    wire next_band_load = write_fund_upper & (next_fundamental_freq != 16'h0000);

    // Selector decode for the result register.
    // The metric is picked by the low three bits,
    // but the format looks at the whole low byte.
    // With bits 7:3 clear the two agree. With any
    // of them set the metric still follows the code
    // while the format falls back to sample format.
    // Code seven names no metric and reads as zero,
    // so a host cannot mistake it for a result.
    wire [STAT_SEL_MSB:0] stat_code = statistic_select[STAT_SEL_MSB:0];
    wire [7:0] select_low = statistic_select[7:0];
    wire code_valid = (stat_code <= STAT_SKEWNESS);
    wire use_int_frac = (select_low == 8'(STAT_STD_DEV)) ||
                        (select_low == 8'(STAT_PEAK)) ||
                        (select_low == 8'(STAT_PEAK_TO_PEAK));
    wire [15:0] stat_raw = code_valid ? stat_values[stat_code] : 16'h0000;

    // The engine gives integer-plus-fraction values as signed 8.8; flipping the integer
    // sign bit turns the upper byte into offset binary without touching the fraction.
    // An integer part below zero thus reads below
    // 0x80 in the upper byte, and zero reads 0x80.
    wire [15:0] stat_int_frac = {~stat_raw[FRAC_INT_MSB], stat_raw[14:0]};

    // Sample-format metrics pass through exactly as the capture buffer would show them.
    // No rounding or saturation is applied here;
    // the engine owns the scaling of every metric.
    wire [15:0] next_statistic_result = use_int_frac ? stat_int_frac : stat_raw;

    // Record counter saturates at nine so a faulty engine value never reads out of range.
    // Clamping rather than masking means an engine
    // that overruns reports a full store instead
    // of wrapping to a small count.
    wire [3:0] record_count_clamped = (record_count_in > RECORD_COUNT_MAX) ?
                                      RECORD_COUNT_MAX : record_count_in;

    // Read data for the addressed word; unmapped words read as zero.
    // The chain is ordered only for form, since at
    // most one hit is high at a time.
    // The word is copied into the answer register
    // at the strobe, so a value that moves later
    // cannot tear the answer while it shifts out.
    logic [15:0] read_word;
    always_comb begin
        if (hit_info_b) begin
            read_word = spectral_record_info_b;
        end else if (hit_record_count) begin
            read_word = record_count;
        end else if (hit_alarm_bin) begin
            read_word = peak_alarm_bin;
        end else if (hit_select) begin
            read_word = statistic_select;
        end else if (hit_result) begin
            read_word = statistic_result;
        end else if (hit_fund) begin
            read_word = fundamental_freq;
        end else begin
            read_word = READ_UNMAPPED;
        end
    end

    // Read-write settings; the fundamental function stays off until the host sets it.
    // Only a complete write frame to the matching
    // word can change either register.
    // Both return to zero on every reset; restoring
    // saved values after power-up is left to the
    // logic that owns the storage.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            statistic_select <= RESET_STAT_SELECT;
            fundamental_freq <= RESET_FUNDAMENTAL_FREQ;
        end else begin
            if (write_select) begin
                statistic_select <= next_statistic_select;
            end
            if (write_fund) begin
                fundamental_freq <= next_fundamental_freq;
            end
        end
    end

    // Read-only views are refreshed from the engines every cycle, never from the host.
    // Registering them costs one clock of lag but
    // keeps the read mux off the engine paths.
    // Unused upper bits are forced to zero, so a
    // host that forgets to mask reads a clean value.
    // The alarm bin keeps all twelve bits, which
    // covers every bin the spectrum can hold.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            record_count <= 16'h0000;
            peak_alarm_bin <= 16'h0000;
            spectral_record_info_b <= 16'h0000;
        end else begin
            record_count <= {12'h000, record_count_clamped};
            peak_alarm_bin <= {4'h0, peak_alarm_bin_in[ALARM_BIN_MSB:0]};
            spectral_record_info_b <= {12'h000, averaging_count[AVG_COUNT_MSB:0]};
        end
    end

    // The result tracks the selector one cycle later, well before any read can follow,
    // since a read frame takes many system clocks to arrive.
    // Counted from the rise of select: two clocks
    // of synchroniser, one to close the frame, one
    // to store the selector and one more here. A
    // read that follows needs sixteen serial clocks
    // at least, so it always sees the new metric.
    // The result also follows engine updates while
    // the selector stands still.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            statistic_result <= RESET_STAT_RESULT;
        end else begin
            statistic_result <= next_statistic_result;
        end
    end

    // A read frame's answer goes out in the following frame; writes leave it alone.
    // A host may interleave writes between a read
    // and the frame that collects its answer.
    // An answer never collected is simply replaced
    // by the next read; the first frame after
    // reset shifts out zeros.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_word <= 16'h0000;
        end else if (host_read) begin
            tx_word <= read_word;
        end
    end

    // Band load strobe is registered so the loader sees the stored fundamental.
    // Without this stage the loader would multiply
    // the old value, since the new byte lands in
    // the same clock as the strobe would.
    // A zero value never raises the strobe, so the
    // limits cannot be cleared by accident.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            band_load <= 1'b0;
        end else begin
            band_load <= next_band_load;
        end
    end

    // Band limits derived from the fundamental.
    // The loader holds the limits between loads
    // and pulses its done flag once, so the alarm
    // engine can restart its scan when they move.
    // The last band stops at the maximum frequency,
    // which does not depend on the fundamental.
    rsr_band_loader #(
        .MAX_FREQ_HZ(MAX_FREQ_HZ)
    ) u_bands (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(band_load),
        .fund_hz(fundamental_freq),
        .bands(bands),
        .bands_loaded(bands_loaded)
    );

endmodule : rsr_record_stats_regs

// ### tb/rsr_record_stats_regs_checker.sv
// Port-level checker for the record, statistic and result register slice.
`timescale 1ns/1ps
module rsr_record_stats_regs_checker #(
    parameter logic [rsr_pkg::BAND_WIDTH-1:0] MAX_FREQ_HZ = 20'h02710
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic sclk_pin,
    input wire logic cs_pin_n,
    input wire logic dout,
    input wire logic [15:0] statistic_select,
    input wire logic [15:0] fundamental_freq,
    input wire rsr_pkg::rsr_band_t bands [rsr_pkg::NUM_BANDS],
    input wire logic bands_loaded
);
    import rsr_pkg::*;

    // All checks share the one clock and drop out while reset is low.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // With the clock pin high and select steady for five cycles, the output bit has no reason to move.
    sequence s_idle_pins;
        (sclk_pin && $stable(cs_pin_n))[*5];
    endsequence

    // A band load is a single-cycle strobe.
    sequence s_load_strobe;
        bands_loaded ##1 !bands_loaded;
    endsequence

    // Settings only move once a frame has closed and the select has been high a while.
    chk_dout_holds: assert property (s_idle_pins |=> $stable(dout))
        else $error("serial output moved without a pin edge");
    chk_select_after_frame: assert property ($changed(statistic_select) |->
        $past(cs_pin_n, 2) && $past(cs_pin_n, 3))
        else $error("selector changed while a frame was open");
    chk_fund_after_frame: assert property ($changed(fundamental_freq) |->
        $past(cs_pin_n, 2) && $past(cs_pin_n, 3))
        else $error("fundamental changed while a frame was open");
    chk_load_pulse_single: assert property (bands_loaded |-> s_load_strobe)
        else $error("band load strobe longer than one cycle");
    chk_load_needs_fund: assert property (bands_loaded |-> fundamental_freq != 16'h0000)
        else $error("bands loaded from a zero fundamental");
    chk_band_first_start: assert property (bands_loaded |->
        32'(bands[0].start_hz) == 32'(fundamental_freq) * 2 / 10)
        else $error("first band start is wrong");
    chk_band_five_stop: assert property (bands_loaded |->
        32'(bands[4].stop_hz) == 32'(fundamental_freq) * 102 / 10)
        else $error("fifth band stop is wrong");
    chk_band_last_stop: assert property (bands_loaded |-> bands[5].stop_hz == MAX_FREQ_HZ)
        else $error("last band stop is not the maximum frequency");
    chk_bands_still: assert property (!bands_loaded |-> $stable(bands[2]))
        else $error("band limits moved without a load strobe");
endmodule : rsr_record_stats_regs_checker

bind rsr_record_stats_regs rsr_record_stats_regs_checker #(.MAX_FREQ_HZ(MAX_FREQ_HZ)) chk_i (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .sclk_pin(sclk_pin),
    .cs_pin_n(cs_pin_n),
    .dout(dout),
    .statistic_select(statistic_select),
    .fundamental_freq(fundamental_freq),
    .bands(bands),
    .bands_loaded(bands_loaded)
);

// ### tb/rsr_record_stats_regs_tb.sv
// Self-checking bench for the record, statistic and result register slice.
`timescale 1ns/1ps
module rsr_record_stats_regs_tb;
    import rsr_pkg::*;
    localparam logic [BAND_WIDTH-1:0] FMAX = 20'h02EE0;
    logic sys_clk, reset_n, sclk_pin, cs_pin_n, din_pin, dout, bands_loaded;
    logic [15:0] averaging_count, statistic_select, fundamental_freq;
    logic [3:0] record_count_in;
    logic [11:0] peak_alarm_bin_in;
    logic [NUM_STATS-1:0][15:0] stat_values;
    rsr_band_t bands [NUM_BANDS];
    int num_errors = 0;
    int compares = 0;
    int loads = 0;

    rsr_record_stats_regs #(.MAX_FREQ_HZ(FMAX)) rsr_record_stats_regs_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .sclk_pin(sclk_pin), .cs_pin_n(cs_pin_n),
        .din_pin(din_pin), .dout(dout), .averaging_count(averaging_count),
        .record_count_in(record_count_in), .peak_alarm_bin_in(peak_alarm_bin_in),
        .stat_values(stat_values), .statistic_select(statistic_select),
        .fundamental_freq(fundamental_freq), .bands(bands), .bands_loaded(bands_loaded)
    );

    // Free-running 200 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Counts load strobes, so a missing or extra load shows up as a count.
    always @(negedge sys_clk) begin
        if (bands_loaded === 1'b1) begin
            loads++;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    // One 16-bit frame; half periods of six cycles keep clear of the synchroniser delay.
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_pin_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        for (int i = 15; i >= 0; i--) begin
            sclk_pin = 1'b0;
            din_pin = tx[i];
            repeat (6) @(negedge sys_clk);
            rx[i] = dout;
            sclk_pin = 1'b1;
            repeat (6) @(negedge sys_clk);
        end
        cs_pin_n = 1'b1;
        din_pin = ~din_pin;
        repeat (10) @(negedge sys_clk);
    endtask : xfer

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        logic [15:0] unused;
        xfer({1'b1, addr, data}, unused);
    endtask : wr

    // The answer to a read arrives during the following frame.
    task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp);
        logic [15:0] got;
        xfer({1'b0, addr, 8'h00}, got);
        xfer(16'h0000, got);
        check($sformatf("read %h", addr), 32'(got), 32'(exp));
    endtask : rd_chk

    function automatic logic [15:0] raw(input int i);
        return 16'h0F35 + 16'(16'h5300 * i);
    endfunction : raw

    // Deviation, peak and span come back offset binary; an unused code reads zero.
    function automatic logic [15:0] fmt(input int c);
        return (c == 7) ? 16'h0000 : (c >= 1 && c <= 3) ? raw(c) ^ 16'h8000 : raw(c);
    endfunction : fmt

    task automatic chk_bands(input int f);
        for (int k = 0; k < NUM_BANDS; k++) begin
            check("band start", 32'(bands[k].start_hz),
                f * BAND_START_TENTHS[k] / TENTHS_DIV);
            check("band stop", 32'(bands[k].stop_hz), (k == NUM_BANDS - 1) ? 32'(FMAX) :
                f * BAND_STOP_TENTHS[k] / TENTHS_DIV);
        end
    endtask : chk_bands

    // Cuts a hang short and reports it as a failure.
    initial begin
        #300us;
        num_errors++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        reset_n = 1'b0;
        sclk_pin = 1'b1;
        cs_pin_n = 1'b1;
        din_pin = 1'b0;
        averaging_count = 16'hABC7;
        record_count_in = 4'hC;
        peak_alarm_bin_in = 12'h7FF;
        for (int i = 0; i < NUM_STATS; i++) begin
            stat_values[i] = raw(i);
        end
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check("select", 32'(statistic_select), 32'(RESET_STAT_SELECT));
        check("fundamental", 32'(fundamental_freq), 32'(RESET_FUNDAMENTAL_FREQ));
        rd_chk(7'h69, 16'h0007);
        rd_chk(ADDR_RECORD_COUNT, 16'h0009);
        record_count_in = 4'h5;
        rd_chk(7'h6B, 16'h0005);
        rd_chk(ADDR_PEAK_ALARM_BIN, 16'h07FF);
        wr(ADDR_RECORD_COUNT, 8'hFF);
        wr(7'h71, 8'hFF);
        rd_chk(ADDR_RECORD_COUNT, 16'h0005);
        rd_chk(ADDR_PEAK_ALARM_BIN, 16'h07FF);
        rd_chk(7'h44, READ_UNMAPPED);
        // Every selector code, with a stray write to the result in the middle.
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_STAT_SELECT, 8'(c));
            if (c == 3) begin
                wr(ADDR_STAT_RESULT, 8'hFF);
            end
            check("select", 32'(statistic_select), 32'(c));
            rd_chk(ADDR_STAT_RESULT, fmt(c));
        end
        // Upper selector bits are stored; the format follows the whole low byte.
        wr(7'h73, 8'hA5);
        wr(ADDR_STAT_SELECT, 8'h0A);
        check("select", 32'(statistic_select), 32'h0000A50A);
        rd_chk(ADDR_STAT_RESULT, raw(2));
        wr(7'h7B, 8'h03);
        check("loads", loads, 1);
        chk_bands(768);
        wr(ADDR_FUNDAMENTAL_FREQ, 8'hE8);
        check("loads", loads, 1);
        rd_chk(ADDR_FUNDAMENTAL_FREQ, 16'h03E8);
        wr(7'h7B, 8'h03);
        chk_bands(1000);
        wr(ADDR_FUNDAMENTAL_FREQ, 8'h00);
        wr(7'h7B, 8'h00);
        check("loads", loads, 2);
        check("fundamental", 32'(fundamental_freq), 32'h00000000);
        chk_bands(1000);
        tally_and_finish();
    end
endmodule : rsr_record_stats_regs_tb
